//--- rtl/lprt_pkg.sv
// shared constants, command and state types for the refresh and precharge tracker
package lprt_pkg;

	// ==========================================================
	// geometry and command/address field positions
	localparam int BANK_COUNT = 8;
	localparam int BANK_W = 3;
	localparam int CA_W = 10;
	localparam int TIMER_W = 8;
	localparam int CA_BA_LO = 7;
	localparam int CA_BA_HI = 9;
	localparam int CA_ALL_BANK = 4;
	localparam int CA_REF_ALL = 3;
	localparam int CA_AUTO_PRE = 0;
	localparam logic [BANK_W-1:0] BANK_FIRST = 3'h0;
	localparam logic [BANK_W-1:0] BANK_LAST = 3'h7;
	localparam logic [BANK_W-1:0] BANK_STEP = 3'h1;

	// ==========================================================
	// timing, times in picoseconds, latencies in clk cycles, burst length in beats (two per clk cycle)
	localparam int CLK_PERIOD_PS = 50000;
	localparam int BURST_LEN = 4;
	localparam int READ_LAT = 3;
	localparam int WRITE_LAT = 1;
	localparam int T_RTP_PS = 7500;
	localparam int T_WR_PS = 15000;
	localparam int T_RPPB_PS = 18000;
	localparam int T_RPAB_PS = 21000;
	localparam int T_RFCPB_PS = 60000;
	localparam int T_RFCAB_PS = 130000;

	function automatic int ruCycles(input int ps);
		int c;
		c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
		return (c < 1) ? 1 : c;
	endfunction

	function automatic int maxInt(input int a, input int b);
		return (a > b) ? a : b;
	endfunction

	localparam int RD_AP_CYC = BURST_LEN / 2 + maxInt(2, ruCycles(T_RTP_PS)) - 2;
	localparam int WR_AP_CYC = WRITE_LAT + BURST_LEN / 2 + ruCycles(T_WR_PS) + 1;
	localparam logic [TIMER_W-1:0] RD_AP_LOAD = TIMER_W'(maxInt(1, RD_AP_CYC));
	localparam logic [TIMER_W-1:0] WR_AP_LOAD = TIMER_W'(WR_AP_CYC);
	localparam logic [TIMER_W-1:0] RPPB_LOAD = TIMER_W'(ruCycles(T_RPPB_PS));
	localparam logic [TIMER_W-1:0] RPAB_LOAD = TIMER_W'(ruCycles(T_RPAB_PS));
	localparam logic [TIMER_W-1:0] RFCPB_LOAD = TIMER_W'(ruCycles(T_RFCPB_PS));
	localparam logic [TIMER_W-1:0] RFCAB_LOAD = TIMER_W'(ruCycles(T_RFCAB_PS));
	localparam logic [TIMER_W-1:0] BURST_HALF_LOAD = TIMER_W'(BURST_LEN / 2);
	localparam logic [TIMER_W-1:0] TIMER_ONE = 8'h01;
	localparam logic [TIMER_W-1:0] TIMER_ZERO = 8'h00;

	// ==========================================================
	// types
	typedef enum {CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_BST, CMD_PRE, CMD_REFPB, CMD_REFAB, CMD_OTHER} lprt_cmd_t;

	typedef enum {BANK_IDLE, BANK_ACTIVE, BANK_AP_WAIT, BANK_PRECHARGE, BANK_REFRESH} lprt_bank_state_t;

	typedef struct packed {
		logic csN;
		logic [CA_W-1:0] caRise;
		logic [CA_W-1:0] caFall;
	} lprt_cmd_bus_t;

endpackage

//--- rtl/lprt_bank_tracker.sv
// device-side bank state, precharge timing and per-bank refresh counter
`timescale 1ns/10ps

// Behaviour
// - each bank's precharge period restarts at its latest precharge of any kind.
// - auto-precharge bursts are never cut short; seamless other-bank bursts continue.
// - refresh decodes from cs low, ca0 low, ca1 low, ca2 high; ca3 picks all-bank.
// - per-bank refresh is accepted only with eight banks.
// - per-bank refresh hits the counter's bank, then counter steps 0 to 7, wrapping.
// - reset command and self-refresh exit clear the refresh counter.
// - counter value names banks like the single-bank precharge bank bits.
// - during per-bank refresh only the refreshed bank is unavailable.
// - a finished per-bank refresh leaves its bank idle.
// - all-bank refresh needs all banks idle and clears the counter.
module lprt_bank_tracker (
	input wire logic clk,
	input wire logic reset,
	input wire logic clkEn,
	input wire lprt_pkg::lprt_cmd_bus_t cmdBus,
	input wire logic resetCmd,
	input wire logic selfRefreshExit,
	output logic [lprt_pkg::BANK_COUNT-1:0] bankActive,
	output logic [lprt_pkg::BANK_COUNT-1:0] bankIdle,
	output logic [lprt_pkg::BANK_W-1:0] refreshCount,
	output logic refreshAccepted,
	output logic cmdError
);

	// ==========================================================
	// command decode
	function automatic lprt_pkg::lprt_cmd_t decodeCmd(input lprt_pkg::lprt_cmd_bus_t b);
		logic [3:0] op;
		op = b.caRise[3:0];
		if (b.csN) begin
			return lprt_pkg::CMD_NOP;
		end
		casez (op)
			4'b??10: return lprt_pkg::CMD_ACT;
			4'b?101: return lprt_pkg::CMD_RD;
			4'b?001: return lprt_pkg::CMD_WR;
			4'b0011: return lprt_pkg::CMD_BST;
			4'b1011: return lprt_pkg::CMD_PRE;
			4'b0100: return lprt_pkg::CMD_REFPB;
			4'b1100: return lprt_pkg::CMD_REFAB;
			default: return lprt_pkg::CMD_OTHER;
		endcase
	endfunction

	lprt_pkg::lprt_cmd_t cmd;
	logic [lprt_pkg::BANK_W-1:0] bankAddr;
	logic autoPre;
	logic allBank;
	logic eightBanks;
	logic refPbOk;
	logic refAbOk;
	logic burstStopBad;
	logic [lprt_pkg::BANK_COUNT-1:0] bankErr;
	logic [lprt_pkg::BANK_COUNT-1:0] next_active;
	logic [lprt_pkg::BANK_COUNT-1:0] next_idle;
	logic [lprt_pkg::BANK_COUNT-1:0] curIdle;
	logic [lprt_pkg::TIMER_W-1:0] apBurstLeft;

	assign cmd = decodeCmd(cmdBus);
	// bank bits share the single-bank precharge layout
	assign bankAddr = cmdBus.caRise[lprt_pkg::CA_BA_HI:lprt_pkg::CA_BA_LO];
	assign autoPre = cmdBus.caFall[lprt_pkg::CA_AUTO_PRE];
	assign allBank = cmdBus.caRise[lprt_pkg::CA_ALL_BANK];
	assign eightBanks = (lprt_pkg::BANK_COUNT == 8);
	assign refPbOk = (cmd == lprt_pkg::CMD_REFPB) && eightBanks && curIdle[refreshCount];
	assign refAbOk = (cmd == lprt_pkg::CMD_REFAB) && (&curIdle);
	// a burst stop may not cut an auto-precharge burst; it is flagged and has no effect
	assign burstStopBad = (cmd == lprt_pkg::CMD_BST) && (apBurstLeft != lprt_pkg::TIMER_ZERO);

	// ==========================================================
	// per-bank state machines
	genvar gb;
	generate
		for (gb = 0; gb < lprt_pkg::BANK_COUNT; gb++) begin : g_bank
			lprt_pkg::lprt_bank_state_t state;
			lprt_pkg::lprt_bank_state_t next_state;
			logic [lprt_pkg::TIMER_W-1:0] timer;
			logic [lprt_pkg::TIMER_W-1:0] next_timer;
			logic hit;
			logic preHit;
			logic timerDone;

			assign hit = (bankAddr == lprt_pkg::BANK_W'(gb));
			assign preHit = (cmd == lprt_pkg::CMD_PRE) && (hit || allBank);
			assign timerDone = (timer <= lprt_pkg::TIMER_ONE);
			assign curIdle[gb] = (state == lprt_pkg::BANK_IDLE);

			always_comb begin
				next_state = state;
				next_timer = timer;
				bankErr[gb] = 1'b0;
				// commands to other banks never disturb this one
				case (state)
					lprt_pkg::BANK_IDLE: begin
						if (cmd == lprt_pkg::CMD_ACT && hit) begin
							next_state = lprt_pkg::BANK_ACTIVE;
						end else if (refPbOk && refreshCount == lprt_pkg::BANK_W'(gb)) begin
							next_state = lprt_pkg::BANK_REFRESH;
							next_timer = lprt_pkg::RFCPB_LOAD;
						end else if (refAbOk) begin
							next_state = lprt_pkg::BANK_REFRESH;
							next_timer = lprt_pkg::RFCAB_LOAD;
						end else if (preHit) begin
							next_state = lprt_pkg::BANK_PRECHARGE;
							next_timer = allBank ? lprt_pkg::RPAB_LOAD : lprt_pkg::RPPB_LOAD;
						end
						if ((cmd == lprt_pkg::CMD_RD || cmd == lprt_pkg::CMD_WR) && hit) begin
							bankErr[gb] = 1'b1;
						end
					end
					lprt_pkg::BANK_ACTIVE: begin
						if (preHit) begin
							next_state = lprt_pkg::BANK_PRECHARGE;
							next_timer = allBank ? lprt_pkg::RPAB_LOAD : lprt_pkg::RPPB_LOAD;
						end else if (cmd == lprt_pkg::CMD_RD && hit && autoPre) begin
							next_state = lprt_pkg::BANK_AP_WAIT;
							next_timer = lprt_pkg::RD_AP_LOAD;
						end else if (cmd == lprt_pkg::CMD_WR && hit && autoPre) begin
							next_state = lprt_pkg::BANK_AP_WAIT;
							next_timer = lprt_pkg::WR_AP_LOAD;
						end
						if (cmd == lprt_pkg::CMD_ACT && hit) begin
							bankErr[gb] = 1'b1;
						end
					end
					lprt_pkg::BANK_AP_WAIT: begin
						// precharge requests are ignored: the auto-precharge runs to its end
						if (timerDone) begin
							next_state = lprt_pkg::BANK_PRECHARGE;
							next_timer = lprt_pkg::RPPB_LOAD;
						end else begin
							next_timer = timer - lprt_pkg::TIMER_ONE;
						end
						if ((cmd == lprt_pkg::CMD_ACT || cmd == lprt_pkg::CMD_RD || cmd == lprt_pkg::CMD_WR) && hit) begin
							bankErr[gb] = 1'b1;
						end
					end
					lprt_pkg::BANK_PRECHARGE: begin
						if (preHit) begin
							next_timer = allBank ? lprt_pkg::RPAB_LOAD : lprt_pkg::RPPB_LOAD;
						end else if (timerDone) begin
							next_state = lprt_pkg::BANK_IDLE;
						end else begin
							next_timer = timer - lprt_pkg::TIMER_ONE;
						end
						if ((cmd == lprt_pkg::CMD_ACT || cmd == lprt_pkg::CMD_RD || cmd == lprt_pkg::CMD_WR) && hit) begin
							bankErr[gb] = 1'b1;
						end
					end
					lprt_pkg::BANK_REFRESH: begin
						if (timerDone) begin
							next_state = lprt_pkg::BANK_IDLE;
						end else begin
							next_timer = timer - lprt_pkg::TIMER_ONE;
						end
						if ((cmd == lprt_pkg::CMD_ACT || cmd == lprt_pkg::CMD_RD || cmd == lprt_pkg::CMD_WR) && hit) begin
							bankErr[gb] = 1'b1;
						end
					end
					default: begin
						next_state = lprt_pkg::BANK_IDLE;
						next_timer = lprt_pkg::TIMER_ZERO;
					end
				endcase
			end

			assign next_active[gb] = (next_state == lprt_pkg::BANK_ACTIVE);
			assign next_idle[gb] = (next_state == lprt_pkg::BANK_IDLE);

			always_ff @(posedge clk) begin
				if (reset) begin
					state <= lprt_pkg::BANK_IDLE;
					timer <= lprt_pkg::TIMER_ZERO;
				end else if (clkEn) begin
					state <= next_state;
					timer <= next_timer;
				end
			end
		end
	endgenerate

	// ==========================================================
	// per-bank refresh counter
	always_ff @(posedge clk) begin
		if (reset) begin
			refreshCount <= lprt_pkg::BANK_FIRST;
		end else if (clkEn) begin
			if (resetCmd || selfRefreshExit) begin
				refreshCount <= lprt_pkg::BANK_FIRST;
			end else if (refAbOk) begin
				refreshCount <= lprt_pkg::BANK_FIRST;
			end else if (refPbOk) begin
				refreshCount <= (refreshCount == lprt_pkg::BANK_LAST) ? lprt_pkg::BANK_FIRST
					: refreshCount + lprt_pkg::BANK_STEP;
			end
		end
	end

	// ==========================================================
	// auto-precharge burst guard
	always_ff @(posedge clk) begin
		if (reset) begin
			apBurstLeft <= lprt_pkg::TIMER_ZERO;
		end else if (clkEn) begin
			if ((cmd == lprt_pkg::CMD_RD || cmd == lprt_pkg::CMD_WR) && autoPre && !bankErr[bankAddr]) begin
				apBurstLeft <= lprt_pkg::BURST_HALF_LOAD;
			end else if (apBurstLeft != lprt_pkg::TIMER_ZERO) begin
				apBurstLeft <= apBurstLeft - lprt_pkg::TIMER_ONE;
			end
		end
	end

	// ==========================================================
	// status outputs, registered so they line up with the bank state
	always_ff @(posedge clk) begin
		if (reset) begin
			bankActive <= '0;
			bankIdle <= '1;
			refreshAccepted <= 1'b0;
			cmdError <= 1'b0;
		end else if (clkEn) begin
			bankActive <= next_active;
			bankIdle <= next_idle;
			refreshAccepted <= refPbOk || refAbOk;
			cmdError <= (|bankErr) || burstStopBad || ((cmd == lprt_pkg::CMD_REFPB) && !refPbOk)
				|| ((cmd == lprt_pkg::CMD_REFAB) && !refAbOk);
		end
	end

endmodule // lprt_bank_tracker

//--- dv/lprt_bank_tracker_properties.sv
// concurrent checks on the refresh counter and bank status outputs
`timescale 1ns/10ps
module lprt_bank_tracker_properties (
	input wire logic clk,
	input wire logic reset,
	input wire logic clkEn,
	input wire lprt_pkg::lprt_cmd_bus_t cmdBus,
	input wire logic resetCmd,
	input wire logic selfRefreshExit,
	input wire logic [lprt_pkg::BANK_COUNT-1:0] bankActive,
	input wire logic [lprt_pkg::BANK_COUNT-1:0] bankIdle,
	input wire logic [lprt_pkg::BANK_W-1:0] refreshCount,
	input wire logic refreshAccepted,
	input wire logic cmdError
);
	// ==========================================================
	// command decode
	logic take, isRefPb, isRefAb, isClear, isBst, isApBurst, isRead, pbOk;
	logic [lprt_pkg::BANK_W-1:0] bank;
	assign take = clkEn && !cmdBus.csN;
	assign bank = cmdBus.caRise[9:7];
	assign isRefPb = take && cmdBus.caRise[3:0] == 4'h4;
	assign isRefAb = take && cmdBus.caRise[3:0] == 4'hc;
	assign isClear = clkEn && (resetCmd || selfRefreshExit);
	assign isBst = take && cmdBus.caRise[3:0] == 4'h3;
	assign isApBurst = take && cmdBus.caRise[1:0] == 2'h1 && cmdBus.caFall[0] && bankActive[bank];
	assign isRead = take && cmdBus.caRise[2:0] == 3'h5 && !cmdBus.caFall[0] && bankActive[bank];
	assign pbOk = isRefPb && bankIdle[refreshCount] && !isClear;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	// ==========================================================
	// properties
	property p_step; pbOk |=> refreshAccepted && !cmdError && refreshCount == $past(refreshCount) + 3'h1; endproperty
	a_step: assert property (p_step) else $error("refresh counter did not step");
	property p_busy; pbOk |=> !bankIdle[$past(refreshCount)]; endproperty
	a_busy: assert property (p_busy) else $error("counted bank not taken for refresh");
	// refresh time runs on enabled cycles only, so a frozen clock enable stretches it
	property p_done; (pbOk ##1 clkEn ##1 clkEn) |=> bankIdle[$past(refreshCount, 3)]; endproperty
	a_done: assert property (p_done) else $error("refreshed bank not idle in time");
	property p_all; isRefAb && &bankIdle && !isClear |=> refreshAccepted && refreshCount == 3'h0 && bankIdle == 8'h00;
	endproperty
	a_all: assert property (p_all) else $error("all bank refresh mishandled");
	property p_clear; isClear |=> refreshCount == 3'h0; endproperty
	a_clear: assert property (p_clear) else $error("counter not cleared");
	property p_hold; !(isRefPb || isRefAb || isClear) |=> refreshCount == $past(refreshCount); endproperty
	a_hold: assert property (p_hold) else $error("counter moved without refresh");
	property p_nocut; isApBurst ##1 isBst |=> cmdError; endproperty
	a_nocut: assert property (p_nocut) else $error("auto precharge burst was cut");
	property p_other; isRead && !isClear |=> !cmdError && bankActive[$past(bank)]; endproperty
	a_other: assert property (p_other) else $error("read to active bank refused");
	c_pb: cover property (pbOk);
	c_ab: cover property (isRefAb && &bankIdle);
	c_err: cover property (cmdError);
endmodule // lprt_bank_tracker_properties

//--- dv/lprt_ctrl_model.sv
// command bus driver standing in for the memory controller
`timescale 1ns/10ps
module lprt_ctrl_model (
	input wire logic clk,
	input wire logic go,
	input wire logic [4:0] op,
	input wire logic [2:0] bank,
	input wire logic ap,
	output lprt_pkg::lprt_cmd_bus_t cmdBus
);
	// ==========================================================
	// deselected bus toggles so a stale command never lingers
	logic [9:0] junk = 10'h155;
	always @(posedge clk) junk <= ~junk;
	always_comb begin
		cmdBus.csN = !go;
		cmdBus.caRise = go ? {bank, 2'h0, op} : junk;
		cmdBus.caFall = go ? {9'h000, ap} : ~junk;
	end
endmodule // lprt_ctrl_model

//--- dv/test_lprt_bank_tracker.sv
// self-checking bench for the bank tracker
`timescale 1ns/10ps
`define CHK(a, e) begin checksDone++; if ((a) !== (e)) begin numErrors++; $display("FAIL at %0t got %h exp %h", $time, a, e); end end
module test_lprt_bank_tracker;
	// ==========================================================
	// stimulus state
	localparam logic [4:0] ACT = 5'h02, RD = 5'h05, WR = 5'h01, BST = 5'h03, PRE = 5'h0b, PREA = 5'h1b;
	localparam logic [4:0] REFPB = 5'h04, REFAB = 5'h0c;
	logic clk = 1'b0, reset = 1'b1, clkEn = 1'b1, resetCmd = 1'b0, selfRefreshExit = 1'b0;
	logic go = 1'b0, ap = 1'b0, goSeen;
	logic [4:0] op = 5'h00, note;
	logic [2:0] bank = 3'h0, expCount = 3'h0, refreshCount;
	logic [31:0] rnd = 32'h65af;
	logic [7:0] bankActive, bankIdle;
	logic refreshAccepted, cmdError;
	lprt_pkg::lprt_cmd_bus_t cmdBus;
	logic [4:0] notes[$];
	int numErrors = 0, checksDone = 0, i;

	initial forever #25 clk = ~clk;
	lprt_ctrl_model lprt_ctrl_model_i (.clk(clk), .go(go), .op(op), .bank(bank), .ap(ap), .cmdBus(cmdBus));
	lprt_bank_tracker lprt_bank_tracker_i (.clk(clk), .reset(reset), .clkEn(clkEn), .cmdBus(cmdBus),
		.resetCmd(resetCmd), .selfRefreshExit(selfRefreshExit), .bankActive(bankActive), .bankIdle(bankIdle),
		.refreshCount(refreshCount), .refreshAccepted(refreshAccepted), .cmdError(cmdError));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// the expected counter mirrors the device's, as a controller must
	task automatic send(input logic [4:0] o, input logic [2:0] b, input logic a, input logic acc, input logic err);
		@(negedge clk);
		op = o;
		bank = b;
		ap = a;
		go = 1'b1;
		if (acc && o == REFPB) expCount = expCount + 3'h1;
		if (acc && o == REFAB) expCount = 3'h0;
		notes.push_back({acc, err, expCount});
	endtask

	task automatic idle(input int n);
		@(negedge clk);
		go = 1'b0;
		repeat (n - 1) @(negedge clk);
	endtask

	task automatic completeRun();
		if (numErrors == 0 && checksDone > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	// ==========================================================
	// monitor: one note per command, result visible after its edge
	always @(posedge clk) begin
		goSeen = go && !reset;
		#1;
		if (goSeen) begin
			note = notes.pop_front();
			`CHK({refreshAccepted, cmdError, refreshCount}, note)
		end
	end

	initial begin
		#100000;
		numErrors++;
		completeRun();
	end

	// ==========================================================
	// scenarios
	initial begin
		repeat (2) @(posedge clk);
		@(negedge clk);
		reset = 1'b0;
		for (i = 0; i < 9; i++) begin
			send(REFPB, 3'h0, 1'b0, 1'b1, 1'b0);
			idle(2);
		end
		send(ACT, 3'h1, 1'b0, 1'b0, 1'b0);
		send(REFPB, 3'h0, 1'b0, 1'b0, 1'b1);
		send(REFAB, 3'h0, 1'b0, 1'b0, 1'b1);
		send(PRE, 3'h1, 1'b0, 1'b0, 1'b0);
		idle(2);
		send(ACT, 3'h5, 1'b0, 1'b0, 1'b0);
		send(ACT, 3'h6, 1'b0, 1'b0, 1'b0);
		send(REFPB, 3'h0, 1'b0, 1'b1, 1'b0);
		for (i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			send(RD, 3'h5 + {2'h0, rnd[0]}, 1'b0, 1'b0, 1'b0);
		end
		send(RD, 3'h5, 1'b1, 1'b0, 1'b0);
		send(BST, 3'h5, 1'b0, 1'b0, 1'b1);
		// long gap keeps the read auto-precharge spacings to other banks
		idle(6);
		send(WR, 3'h6, 1'b1, 1'b0, 1'b0);
		send(RD, 3'h6, 1'b0, 1'b0, 1'b1);
		idle(6);
		send(PREA, 3'h0, 1'b0, 1'b0, 1'b0);
		idle(2);
		send(REFAB, 3'h0, 1'b0, 1'b1, 1'b0);
		idle(3);
		for (i = 0; i < 2; i++) begin
			send(REFPB, 3'h0, 1'b0, 1'b1, 1'b0);
			idle(2);
			if (i == 0) resetCmd = 1'b1;
			else selfRefreshExit = 1'b1;
			@(negedge clk);
			resetCmd = 1'b0;
			selfRefreshExit = 1'b0;
			expCount = 3'h0;
			send(REFPB, 3'h0, 1'b0, 1'b1, 1'b0);
			idle(2);
		end
		// a frozen clock enable must swallow the refresh
		clkEn = 1'b0;
		send(REFPB, 3'h0, 1'b0, 1'b0, 1'b0);
		idle(1);
		clkEn = 1'b1;
		send(REFPB, 3'h0, 1'b0, 1'b1, 1'b0);
		idle(2);
		completeRun();
	end
endmodule // test_lprt_bank_tracker

bind lprt_bank_tracker lprt_bank_tracker_properties lprt_bank_tracker_properties_i (.clk(clk), .reset(reset),
	.clkEn(clkEn), .cmdBus(cmdBus), .resetCmd(resetCmd), .selfRefreshExit(selfRefreshExit), .bankActive(bankActive),
	.bankIdle(bankIdle), .refreshCount(refreshCount), .refreshAccepted(refreshAccepted), .cmdError(cmdError));
